//--- wdt_params.svh
// Register map, field positions, reset values and counts of the watchdog reset timer
// Behaviour
// RULE_01 - 8-bit up-counter; wrap raises reset, sets flag
// RULE_02 - Counter starts at zero after reset
// RULE_03 - Counter writes only while counter_write_enable set
// RULE_04 - counter_write_enable changes only with bit7 zero
// RULE_05 - register_write_enable changes only with bit5 zero
// RULE_06 - Run and flag writable only with register_write_enable
// RULE_07 - run_bit changes only with bit3 zero
// RULE_08 - Flag changes only with bit1 zero
// RULE_09 - Count while run_bit set, else hold
// RULE_10 - run_bit cleared by pin reset or write
// RULE_11 - Flag set on overflow; cleared by reset/write
// RULE_12 - Clock mode upper four bits read one
// RULE_13 - Preset value gives 1 to 256 periods
// RULE_14 - Nine counter clocks, oscillator always works
// RULE_15 - Software uses whole-byte writes to control
// RULE_16 - Select 1xxx picks divider, 0xxx oscillator
// RULE_17 - Internal reset held 256 oscillator cycles
// RULE_18 - Counting resumes from the written value
// RULE_19 - Inhibited bit leaves other qualified bits applied
`ifndef WDT_PARAMS_SVH
`define WDT_PARAMS_SVH

// Byte addresses on the register bus
`define WDT_ADR_CTRL 8'h00
`define WDT_ADR_CNT 8'h04
`define WDT_ADR_MODE 8'h08
`define WDT_ADR_ISTAT 8'h0c
`define WDT_ADR_IMASK 8'h10

// Control/status field positions
`define WDT_B_CWE_INH 7
`define WDT_B_CWE 6
`define WDT_B_RWE_INH 5
`define WDT_B_RWE 4
`define WDT_B_RUN_INH 3
`define WDT_B_RUN 2
`define WDT_B_OVF_INH 1
`define WDT_B_OVF 0

// Reset values
`define WDT_CNT_RST 8'h00
`define WDT_MODE_RST 4'hf
`define WDT_MODE_RSVD 4'hf

// Timing counts
`define WDT_CNT_MAX 8'hff
`define WDT_HOLD_LAST 8'hff
`define WDT_DIV_BASE_LOG2 6

`endif

//--- wdt_pkg.sv
// Types shared by the watchdog reset timer modules
package wdt_pkg;
  typedef logic [7:0] wdt_byte_type;
  typedef logic [3:0] wdt_clk_sel_type;
  // Interrupt status layout
  typedef enum logic [1:0] {
    WDT_EV_OVERFLOW = 2'h1,
    WDT_EV_HOLD_END = 2'h2
  } wdt_event_type;
endpackage

//--- wdt_prescaler.sv
// Prescaler producing the watchdog counter tick from the system clock or oscillator
`timescale 1ns/1ps
module wdt_prescaler #(
  parameter int DIV_W = 13
) (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  wdt_tick_if.pre tk
);
  import wdt_pkg::*;
  `include "wdt_params.svh"

  logic [DIV_W-1:0] div_cnt;

  // Mask of the low divider bits that must all be one for the chosen ratio
  function automatic logic [DIV_W-1:0] tap_mask(input logic [2:0] code);
    logic [DIV_W:0] one_hot;
    one_hot = '0;
    one_hot[`WDT_DIV_BASE_LOG2 + code] = 1'b1;
    return one_hot[DIV_W-1:0] - 1'b1;
  endfunction

  // Free-running divider; a select change may give one short period
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 1'b1;
    end
  end

  // One tick per selected period, or per oscillator pulse
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      tk.cnt_tick <= 1'b0;
    end else if (tk.clk_sel[3]) begin // RULE_16
      tk.cnt_tick <= ((div_cnt & tap_mask(tk.clk_sel[2:0])) == tap_mask(tk.clk_sel[2:0])); // RULE_14
    end else begin
      tk.cnt_tick <= tk.osc_tick; // RULE_14
    end
  end
endmodule

//--- wdt_tb.sv
// Self-checking testbench for the watchdog reset timer
`timescale 1ns/1ps
`include "wdt_params.svh"
module testbench;
  // ****************************************
  // Clock, reset and bus signals
  // ****************************************
  logic sys_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic osc_tick_i = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic irq_o;
  logic chip_rst_o;
  int n_mismatch = 0;
  int tests_run = 0;
  logic [7:0] q;
  logic [7:0] q2;

  // 250 MHz system clock
  always #2 sys_clk_i = ~sys_clk_i;

  wdt_top u_dut (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .osc_tick_i(osc_tick_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .irq_o(irq_o), .chip_rst_o(chip_rst_o));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Classic cycle; ack and read data are read at the rising edge, before that edge's register updates land
  task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d, output logic [7:0] r);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= {24'h0, d}; sel <= 4'h1;
    @(posedge sys_clk_i);
    while (wb_ack_o !== 1'b1) begin
      n++;
      if (n > 20) begin
        n_mismatch++;
        close_out();
      end
      @(posedge sys_clk_i);
    end
    r = wb_dat_o[7:0];
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    xfer(a, 1'b1, d, r);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] r);
    xfer(a, 1'b0, 8'h00, r);
  endtask

  // Oscillator pulses, one system clock wide, three idle cycles apart
  task automatic osc(input int n);
    repeat (n) begin
      @(posedge sys_clk_i) osc_tick_i <= 1'b1;
      @(posedge sys_clk_i) osc_tick_i <= 1'b0;
      repeat (2) @(posedge sys_clk_i);
    end
  endtask

  task automatic pin(input string nm, input logic e, input logic g);
    chk(nm, {7'h0, e}, {7'h0, g});
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    rd(`WDT_ADR_CTRL, q); chk("ctrl reset", 8'haa, q);
    rd(`WDT_ADR_CNT, q); chk("cnt reset", 8'h00, q);
    rd(`WDT_ADR_MODE, q); chk("mode reset", 8'hff, q);
    rd(8'h14, q); chk("unmapped", 8'h00, q);
  endtask

  // Each guarded bit moves only with its inhibit bit written as zero
  task automatic t_guards();
    wr(`WDT_ADR_CNT, 8'h33); rd(`WDT_ADR_CNT, q); chk("cnt locked", 8'h00, q);
    wr(`WDT_ADR_CTRL, 8'hff); rd(`WDT_ADR_CTRL, q); chk("all inhibited", 8'haa, q);
    wr(`WDT_ADR_CTRL, 8'h4f); rd(`WDT_ADR_CTRL, q); chk("cwe only", 8'hea, q);
    wr(`WDT_ADR_CNT, 8'h5a); rd(`WDT_ADR_CNT, q); chk("cnt write", 8'h5a, q);
    wr(`WDT_ADR_CTRL, 8'hf4); rd(`WDT_ADR_CTRL, q); chk("run locked", 8'hea, q);
    wr(`WDT_ADR_CTRL, 8'hd0); rd(`WDT_ADR_CTRL, q); chk("rwe set", 8'hfa, q);
    wr(`WDT_ADR_MODE, 8'h00); rd(`WDT_ADR_MODE, q); chk("mode osc", 8'hf0, q);
    osc(3); rd(`WDT_ADR_CNT, q); chk("stopped hold", 8'h5a, q);
  endtask

  // Preset of fd gives an overflow on the third oscillator tick
  task automatic t_overflow();
    wr(`WDT_ADR_IMASK, 8'h01);
    wr(`WDT_ADR_CNT, 8'hfd);
    wr(`WDT_ADR_CTRL, 8'hf4); rd(`WDT_ADR_CTRL, q); chk("run set", 8'hfe, q);
    osc(2); rd(`WDT_ADR_CNT, q); chk("cnt ff", 8'hff, q);
    @(negedge sys_clk_i); pin("no rst early", 1'b0, chip_rst_o);
    osc(1); @(negedge sys_clk_i); pin("rst on wrap", 1'b1, chip_rst_o);
    pin("irq overflow", 1'b1, irq_o);
    rd(`WDT_ADR_CNT, q); chk("cnt wrap", 8'h00, q);
    wr(`WDT_ADR_CTRL, 8'hf2); rd(`WDT_ADR_CTRL, q); chk("run off flag on", 8'hfb, q);
    osc(255); @(negedge sys_clk_i); pin("rst held", 1'b1, chip_rst_o);
    osc(1); @(negedge sys_clk_i); pin("rst ends", 1'b0, chip_rst_o);
    rd(`WDT_ADR_CNT, q); chk("cnt idle", 8'h00, q);
    // The line follows a mask change one cycle after the write lands
    wr(`WDT_ADR_IMASK, 8'h00); @(posedge sys_clk_i); @(negedge sys_clk_i); pin("irq masked", 1'b0, irq_o);
    wr(`WDT_ADR_IMASK, 8'h03); @(posedge sys_clk_i); @(negedge sys_clk_i); pin("irq unmasked", 1'b1, irq_o);
    rd(`WDT_ADR_ISTAT, q); chk("istat", 8'h03, q);
    rd(`WDT_ADR_ISTAT, q); chk("istat clear", 8'h00, q);
    @(negedge sys_clk_i); pin("irq clear", 1'b0, irq_o);
    wr(`WDT_ADR_CTRL, 8'hfc); rd(`WDT_ADR_CTRL, q); chk("flag clear", 8'hfa, q);
  endtask

  // Every divider code: 2 ratio periods between equal-length reads give 2 or 3 ticks
  task automatic t_divider();
    int dlt;
    wr(`WDT_ADR_CTRL, 8'hf4);
    for (int i = 0; i < 8; i++) begin
      wr(`WDT_ADR_MODE, 8'h08 + i[7:0]); rd(`WDT_ADR_MODE, q); chk("mode div", 8'hf8 + i[7:0], q);
      wr(`WDT_ADR_CNT, 8'h00);
      rd(`WDT_ADR_CNT, q);
      repeat (2 << (6 + i)) @(posedge sys_clk_i);
      rd(`WDT_ADR_CNT, q2);
      dlt = int'(q2) - int'(q);
      chk("div ticks", 8'h01, (dlt == 2 || dlt == 3) ? 8'h01 : 8'(dlt));
    end
  endtask

  // Pin reset in mid-run clears run and the whole block
  task automatic t_midreset();
    @(posedge sys_clk_i) srst_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    rd(`WDT_ADR_CTRL, q); chk("ctrl after pin", 8'haa, q);
    rd(`WDT_ADR_CNT, q); chk("cnt after pin", 8'h00, q);
    rd(`WDT_ADR_MODE, q); chk("mode after pin", 8'hff, q);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (8) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    t_reset();
    t_guards();
    t_overflow();
    t_divider();
    t_midreset();
    close_out();
  end
endmodule

//--- wdt_tick_if.sv
// Counter clock selection link between the core and its prescaler
`timescale 1ns/1ps
interface wdt_tick_if;
  wdt_pkg::wdt_clk_sel_type clk_sel;
  logic osc_tick;
  logic cnt_tick;
  modport pre (input clk_sel, input osc_tick, output cnt_tick);
  modport core (output clk_sel, output osc_tick, input cnt_tick);
endinterface

//--- wdt_top.sv
// Watchdog reset timer with Wishbone register access and interrupt
`timescale 1ns/1ps
module wdt_top (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic osc_tick_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  output logic chip_rst_o
);
  import wdt_pkg::*;
  `include "wdt_params.svh"

  // ************************************************************
  // Declarations
  // ************************************************************
  wdt_tick_if tk ();

  wdt_byte_type counter;
  logic counter_write_enable;
  logic register_write_enable;
  logic run_bit;
  logic overflow_reset_flag;
  wdt_clk_sel_type clock_mode;
  logic [1:0] int_status;
  logic [1:0] int_mask;
  wdt_byte_type hold_cnt;
  logic [1:0] next_int_status;

  logic bus_req;
  logic wr_take;
  logic rd_take;
  logic lane0;
  wdt_byte_type wr_byte;
  logic ctrl_wr;
  logic cnt_wr;
  logic cnt_step;
  logic ovf_evt;
  logic hold_end;

  // Read value of the control/status register, inhibit bits read one
  function automatic wdt_byte_type ctrl_view(input logic cwe, input logic rwe,
                                             input logic run, input logic ovf);
    wdt_byte_type v;
    v = 8'haa;
    v[`WDT_B_CWE] = cwe;
    v[`WDT_B_RWE] = rwe;
    v[`WDT_B_RUN] = run;
    v[`WDT_B_OVF] = ovf;
    return v;
  endfunction

  // ************************************************************
  // Prescaler
  // ************************************************************
  assign tk.clk_sel = clock_mode;
  assign tk.osc_tick = osc_tick_i;

  wdt_prescaler #(
    .DIV_W(13)
  ) u_pre (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .tk(tk)
  );

  // ************************************************************
  // Bus slave
  // ************************************************************
  // A write lands on the edge at which the master sees ack
  assign bus_req = wb_cyc_i & wb_stb_i;
  assign wr_take = bus_req & wb_we_i & wb_ack_o;
  assign rd_take = bus_req & ~wb_we_i & wb_ack_o;
  assign lane0 = wb_sel_i[0];
  assign wr_byte = wb_dat_i[7:0];
  assign ctrl_wr = wr_take & lane0 & (wb_adr_i == `WDT_ADR_CTRL);
  assign cnt_wr = wr_take & lane0 & (wb_adr_i == `WDT_ADR_CNT) & counter_write_enable; // RULE_03

  // Ack one cycle after the request, dropped the cycle after
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req & ~wb_ack_o;
    end
  end

  // Read data captured with ack; unmapped addresses read zero
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      wb_dat_o <= '0;
    end else if (bus_req & ~wb_ack_o & ~wb_we_i) begin
      if (wb_adr_i == `WDT_ADR_CTRL) begin
        wb_dat_o <= {24'h0, ctrl_view(counter_write_enable, register_write_enable,
                                      run_bit, overflow_reset_flag)}; // RULE_04 RULE_05 RULE_07 RULE_08
      end else if (wb_adr_i == `WDT_ADR_CNT) begin
        wb_dat_o <= {24'h0, counter};
      end else if (wb_adr_i == `WDT_ADR_MODE) begin
        wb_dat_o <= {24'h0, `WDT_MODE_RSVD, clock_mode}; // RULE_12
      end else if (wb_adr_i == `WDT_ADR_ISTAT) begin
        wb_dat_o <= {30'h0, int_status};
      end else if (wb_adr_i == `WDT_ADR_IMASK) begin
        wb_dat_o <= {30'h0, int_mask};
      end else begin
        wb_dat_o <= '0;
      end
    end else begin
      wb_dat_o <= '0;
    end
  end

  // ************************************************************
  // Control/status register
  // ************************************************************
  // Each guarded bit checks only its own inhibit, so one refused bit
  // does not stop the others in the same write
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      counter_write_enable <= 1'b0;
    end else if (ctrl_wr & ~wr_byte[`WDT_B_CWE_INH]) begin // RULE_04 RULE_19
      counter_write_enable <= wr_byte[`WDT_B_CWE];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      register_write_enable <= 1'b0;
    end else if (ctrl_wr & ~wr_byte[`WDT_B_RWE_INH]) begin // RULE_05 RULE_19
      register_write_enable <= wr_byte[`WDT_B_RWE];
    end
  end

  // Old write-enable value qualifies the run bit, as a byte store sees it
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      run_bit <= 1'b0; // RULE_10
    end else if (ctrl_wr & ~wr_byte[`WDT_B_RUN_INH] & register_write_enable) begin // RULE_06 RULE_07
      run_bit <= wr_byte[`WDT_B_RUN]; // RULE_10
    end
  end

  // Overflow set wins over a clearing write in the same cycle
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      overflow_reset_flag <= 1'b0; // RULE_11
    end else if (ovf_evt) begin
      overflow_reset_flag <= 1'b1; // RULE_01 RULE_11
    end else if (ctrl_wr & ~wr_byte[`WDT_B_OVF_INH] & register_write_enable) begin // RULE_06 RULE_08
      overflow_reset_flag <= wr_byte[`WDT_B_OVF]; // RULE_11
    end
  end

  // Clock mode; a divider change can cut one period short
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      clock_mode <= `WDT_MODE_RST;
    end else if (wr_take & lane0 & (wb_adr_i == `WDT_ADR_MODE)) begin
      clock_mode <= wr_byte[3:0]; // RULE_16
    end
  end

  // ************************************************************
  // Watchdog counter
  // ************************************************************
  assign cnt_step = tk.cnt_tick & run_bit; // RULE_09
  assign ovf_evt = cnt_step & ~cnt_wr & (counter == `WDT_CNT_MAX); // RULE_01

  // A software write beats a count in the same cycle
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      counter <= `WDT_CNT_RST; // RULE_02
    end else if (cnt_wr) begin
      counter <= wr_byte; // RULE_13 RULE_18
    end else if (cnt_step) begin
      counter <= counter + 1'b1; // RULE_01 RULE_09
    end
  end

  // ************************************************************
  // Internal reset stretcher
  // ************************************************************
  assign hold_end = chip_rst_o & tk.osc_tick & (hold_cnt == `WDT_HOLD_LAST);

  // Held for 256 oscillator pulses; a new overflow restarts the count
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      chip_rst_o <= 1'b0;
      hold_cnt <= 8'h00;
    end else if (ovf_evt) begin
      chip_rst_o <= 1'b1; // RULE_01 RULE_17
      hold_cnt <= 8'h00;
    end else if (hold_end) begin
      chip_rst_o <= 1'b0; // RULE_17
    end else if (chip_rst_o & tk.osc_tick) begin
      hold_cnt <= hold_cnt + 1'b1; // RULE_17
    end
  end

  // ************************************************************
  // Interrupts
  // ************************************************************
  // Read clears, but an event in that same cycle survives
  always_comb begin
    next_int_status = int_status;
    if (rd_take & (wb_adr_i == `WDT_ADR_ISTAT)) begin
      next_int_status = 2'h0;
    end
    if (ovf_evt) begin
      next_int_status = next_int_status | WDT_EV_OVERFLOW;
    end
    if (hold_end) begin
      next_int_status = next_int_status | WDT_EV_HOLD_END;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      int_status <= 2'h0;
    end else begin
      int_status <= next_int_status;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      int_mask <= 2'h0;
    end else if (wr_take & lane0 & (wb_adr_i == `WDT_ADR_IMASK)) begin
      int_mask <= wr_byte[1:0];
    end
  end

  // Registered from the next status, so the line changes with status and follows the mask by one cycle
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(next_int_status & int_mask);
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);

  sequence seq_wrap;
    run_bit && tk.cnt_tick && !cnt_wr && counter == 8'hff;
  endsequence

  sequence seq_guarded_ctrl(int b);
    ctrl_wr && wr_byte[b];
  endsequence

  ovf_sets_flag_a: assert property (seq_wrap |=> overflow_reset_flag && counter == 8'h00) // RULE_01
    else $error("wrap did not set flag or zero counter");

  ovf_raises_reset_a: assert property (seq_wrap |=> chip_rst_o && hold_cnt == 8'h00) // RULE_17
    else $error("wrap did not start internal reset");

  cnt_init_zero_a: assert property (disable iff (1'b0) srst_i |=> counter == 8'h00) // RULE_02
    else $error("counter not zero after reset");

  cnt_write_guard_a: assert property (wr_take && lane0 && wb_adr_i == `WDT_ADR_CNT && !counter_write_enable
                                      && !cnt_step |=> $stable(counter)) // RULE_03
    else $error("counter written while write enable clear");

  cwe_inhibit_a: assert property (seq_guarded_ctrl(7) |=> $stable(counter_write_enable)) // RULE_04
    else $error("counter write enable changed with inhibit set");

  rwe_inhibit_a: assert property (seq_guarded_ctrl(5) |=> $stable(register_write_enable)) // RULE_05
    else $error("register write enable changed with inhibit set");

  run_guard_a: assert property (ctrl_wr && (wr_byte[3] || !register_write_enable) |=> $stable(run_bit)) // RULE_07
    else $error("run bit changed without qualification");

  flag_guard_a: assert property (ctrl_wr && (wr_byte[1] || !register_write_enable) && !ovf_evt
                                 |=> $stable(overflow_reset_flag)) // RULE_08
    else $error("overflow flag changed without qualification");

  stop_holds_a: assert property (!run_bit && !cnt_wr |=> counter == $past(counter)) // RULE_09
    else $error("counter moved while stopped");

  // Read data is captured on the edge that raises ack, so it is held against the bits sampled at that edge
  ctrl_readback_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == `WDT_ADR_CTRL
                                    |-> wb_dat_o[7:0] == ctrl_view($past(counter_write_enable),
                                        $past(register_write_enable), $past(run_bit),
                                        $past(overflow_reset_flag))) // RULE_05
    else $error("control readback wrong");

  mode_rsvd_ones_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == `WDT_ADR_MODE
                                     |-> wb_dat_o[7:4] == 4'hf) // RULE_12
    else $error("reserved mode bits not one");

  hold_length_a: assert property ($fell(chip_rst_o) |-> $past(hold_cnt) == 8'hff && $past(tk.osc_tick)) // RULE_17
    else $error("internal reset released early");

  resume_from_write_a: assert property (cnt_wr |=> counter == $past(wr_byte)) // RULE_18
    else $error("counter did not load written value");

  osc_select_a: assert property (!clock_mode[3] |=> tk.cnt_tick == $past(osc_tick_i)) // RULE_16
    else $error("oscillator not selected by top bit zero");
endmodule
